// ---- core/uart_pkg.sv ----
// Shared constants and types of the serial port with break reset
package uart_pkg;
  localparam int CLK_HZ = 250000000;
  localparam int OVERSAMPLE = 16;
  // Bit rate equals setting / 0.004096 s, sampled at OVERSAMPLE per bit
  localparam int BAUD_DIVIDEND_US = 4096;
  localparam int BAUD_MODULUS = (CLK_HZ / 1000000) * BAUD_DIVIDEND_US / OVERSAMPLE;
  // Break duration counted in units of this many microseconds
  localparam int BREAK_UNIT_US = 1000;
  localparam int BREAK_UNIT_CYCLES = (CLK_HZ / 1000000) * BREAK_UNIT_US;

  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_BAUD = 8'h04;
  localparam logic [7:0] REG_TIMEOUT = 8'h08;
  localparam logic [7:0] REG_TXDATA = 8'h0C;
  localparam logic [7:0] REG_RXDATA = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_MASK = 8'h18;
  localparam logic [7:0] REG_STATE = 8'h1C;

  localparam int CTRL_W = 6;
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_PARITY_EN = 1;
  localparam int CTRL_PARITY_ODD = 2;
  localparam int CTRL_TWO_STOP = 3;
  localparam int CTRL_FLOW_EN = 4;
  localparam int CTRL_SEND_BREAK = 5;
  localparam logic [5:0] CTRL_RESET = 6'h01;
  localparam logic [15:0] BAUD_RESET = 16'h01D8;
  localparam logic [15:0] TIMEOUT_RESET = 16'h01A4;

  localparam int NUM_EVENTS = 6;
  localparam int EV_RX_DONE = 0;
  localparam int EV_TX_DONE = 1;
  localparam int EV_PARITY_ERR = 2;
  localparam int EV_FRAME_ERR = 3;
  localparam int EV_OVERRUN = 4;
  localparam int EV_BREAK = 5;

  typedef enum logic [2:0] {
    SER_IDLE = 3'b000,
    SER_START = 3'b001,
    SER_DATA = 3'b010,
    SER_PARITY = 3'b011,
    SER_STOP = 3'b100
  } serState_t;
endpackage : uart_pkg

// ---- core/baud_if.sv ----
// Rate setting and oversample tick between the port and its rate generator
interface baud_if;
  logic [15:0] setting;
  logic tick;
  modport gen (input setting, output tick);
  modport user (output setting, input tick);
endinterface : baud_if

// ---- core/uart_baud_gen.sv ----
// Fractional rate generator producing the oversample tick
module uart_baud_gen
(
  input wire logic clock,
  input wire logic rst,
  baud_if.gen bus
);
  import uart_pkg::*;
  localparam logic [16:0] MODULUS = 17'(BAUD_MODULUS); // RL5

  logic [16:0] acc_reg;
  logic [16:0] acc_next;
  logic tick_reg;
  logic tick_next;
  logic [16:0] sum;

  always_comb
  begin
    sum = acc_reg + {1'b0, bus.setting};
    acc_next = sum;
    tick_next = 1'b0;
    if (sum >= MODULUS) // RL4
    begin
      acc_next = sum - MODULUS;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      acc_reg <= 17'h00000;
      tick_reg <= 1'b0;
    end
    else
    begin
      acc_reg <= acc_next;
      tick_reg <= tick_next;
    end
  end

  assign bus.tick = tick_reg;
endmodule : uart_baud_gen

// ---- core/uart_break_reset.sv ----
// Serial port with flow control, break detection chip reset and break send
// Summary of operation
// (RL1) Active-low RTS/CTS; send only while CTS low
// (RL2) 8 data bits, parity none/odd/even, 1-2 stops
// (RL3) Any rate 1200 baud to 3.0 Mbaud
// (RL4) Rate equals setting divided by 0.004096
// (RL5) Standard settings give standard rates
// (RL6) Long receive low requests full chip reset
// (RL7) Can send break by holding transmit low
// (RL8) Host pulls receive line high when idle
// (RL9) Four chip reset sources combined
// (RL10) Outputs float during reset, pads keep pulls
// (RL11) Warm reset keeps rate, cold reloads default
// (RL12) Serial outputs high impedance while in reset
// (RL13) Low start bit, LSB first, idle high
//
// The register addresses and the strobed register port are this design's own decisions.
module uart_break_reset
#(
  parameter int BREAK_UNIT = uart_pkg::BREAK_UNIT_CYCLES
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [uart_pkg::ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  input wire logic rxLine,
  input wire logic ctsN,
  output logic txLine,
  output logic txOe,
  output logic rtsN,
  output logic rtsOe,
  output logic irq,
  input wire logic resetPin,
  input wire logic powerOnDetect,
  input wire logic watchdogExpire,
  input wire logic coldReset,
  output logic chipResetReq
);
  import uart_pkg::*;
  localparam int TICK_MAX_WAIT = 128;

  baud_if baudBus ();

  logic [CTRL_W-1:0] ctrl_reg, ctrl_next;
  logic [15:0] baud_reg, baud_next;
  logic [15:0] timeout_reg, timeout_next;
  logic [NUM_EVENTS-1:0] status_reg, status_next, mask_reg, mask_next;
  logic [31:0] rdata_reg, rdata_next;
  logic irq_reg, irq_next;
  logic [NUM_EVENTS-1:0] events;
  logic txLoad, rxTake;

  serState_t txState_reg, txState_next;
  logic [3:0] txTick_reg, txTick_next;
  logic [2:0] txBit_reg, txBit_next;
  logic txStop2_reg, txStop2_next;
  logic [7:0] txShift_reg, txShift_next, txHold_reg, txHold_next;
  logic txLine_reg, txLine_next, txOe_reg, txOe_next, txDone;

  serState_t rxState_reg, rxState_next;
  logic [3:0] rxTick_reg, rxTick_next;
  logic [2:0] rxBit_reg, rxBit_next;
  logic [7:0] rxShift_reg, rxShift_next, rxData_reg, rxData_next;
  logic rxFull_reg, rxFull_next, rxPar_reg, rxPar_next;
  logic rtsN_reg, rtsN_next, rtsOe_reg, rtsOe_next;
  logic rxDone, parErr, frameErr, overrun;

  logic [31:0] brkPre_reg, brkPre_next;
  logic [15:0] brkUnits_reg, brkUnits_next;
  logic brkFired_reg, brkFired_next, brkFire;
  logic chipReq_reg, chipReq_next;

  assign baudBus.setting = baud_reg;

  uart_baud_gen baudGen (
    .clock(clock),
    .rst(rst),
    .bus(baudBus)
  );

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
    hit = (a == r);
  endfunction : hit

  // Register file, sticky events and interrupt
  always_comb
  begin
    ctrl_next = ctrl_reg;
    baud_next = baud_reg;
    timeout_next = timeout_reg;
    mask_next = mask_reg;
    status_next = status_reg;
    rdata_next = 32'h00000000;
    txLoad = 1'b0;
    rxTake = 1'b0;
    if (regWrite)
    begin
      if (hit(regAddr, REG_CTRL))
        ctrl_next = regWdata[CTRL_W-1:0];
      else if (hit(regAddr, REG_BAUD))
        baud_next = regWdata[15:0]; // RL3
      else if (hit(regAddr, REG_TIMEOUT))
        timeout_next = regWdata[15:0];
      else if (hit(regAddr, REG_TXDATA))
        txLoad = 1'b1;
      else if (hit(regAddr, REG_STATUS))
        status_next = status_reg & ~regWdata[NUM_EVENTS-1:0];
      else if (hit(regAddr, REG_MASK))
        mask_next = regWdata[NUM_EVENTS-1:0];
    end
    // A new event wins over a clear in the same cycle
    status_next = status_next | events;
    if (regRead)
    begin
      if (hit(regAddr, REG_CTRL))
        rdata_next = {26'h0000000, ctrl_reg};
      else if (hit(regAddr, REG_BAUD))
        rdata_next = {16'h0000, baud_reg};
      else if (hit(regAddr, REG_TIMEOUT))
        rdata_next = {16'h0000, timeout_reg};
      else if (hit(regAddr, REG_RXDATA))
      begin
        rdata_next = {24'h000000, rxData_reg};
        rxTake = 1'b1;
      end
      else if (hit(regAddr, REG_STATUS))
        rdata_next = {26'h0000000, status_reg};
      else if (hit(regAddr, REG_MASK))
        rdata_next = {26'h0000000, mask_reg};
      else if (hit(regAddr, REG_STATE))
        rdata_next = {27'h0000000, rxLine, brkFired_reg, rxFull_reg,
                      rxState_reg != SER_IDLE, txState_reg != SER_IDLE};
    end
    irq_next = |(status_next & mask_next);
  end

  assign events = {brkFire, overrun, frameErr, parErr, txDone, rxDone};

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      ctrl_reg <= CTRL_RESET;
      timeout_reg <= TIMEOUT_RESET;
      status_reg <= '0;
      mask_reg <= '0;
      rdata_reg <= 32'h00000000;
      irq_reg <= 1'b0;
      if (coldReset)
        baud_reg <= BAUD_RESET; // RL11
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      baud_reg <= baud_next;
      timeout_reg <= timeout_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
    end
  end

  // Transmitter
  always_comb
  begin
    txState_next = txState_reg;
    txTick_next = txTick_reg;
    txBit_next = txBit_reg;
    txStop2_next = txStop2_reg;
    txShift_next = txShift_reg;
    txHold_next = txHold_reg;
    txDone = 1'b0;
    case (txState_reg)
      SER_IDLE:
        if (txLoad && ctrl_reg[CTRL_ENABLE] && !(ctrl_reg[CTRL_FLOW_EN] && ctsN)) // RL1
        begin
          txState_next = SER_START; // RL13
          txShift_next = regWdata[7:0];
          txHold_next = regWdata[7:0];
          txTick_next = 4'h0;
        end
      default:
        if (baudBus.tick)
        begin
          txTick_next = txTick_reg + 4'h1;
          if (txTick_reg == 4'(OVERSAMPLE - 1))
          begin
            case (txState_reg)
              SER_START:
              begin
                txState_next = SER_DATA;
                txBit_next = 3'h0;
              end
              SER_DATA:
              begin
                txShift_next = {1'b0, txShift_reg[7:1]}; // RL13
                txBit_next = txBit_reg + 3'h1;
                if (txBit_reg == 3'h7)
                  txState_next = ctrl_reg[CTRL_PARITY_EN] ? SER_PARITY : SER_STOP; // RL2
                txStop2_next = ctrl_reg[CTRL_TWO_STOP];
              end
              SER_PARITY:
                txState_next = SER_STOP;
              default:
                if (txStop2_reg)
                  txStop2_next = 1'b0; // RL2
                else
                begin
                  txState_next = SER_IDLE;
                  txDone = 1'b1;
                end
            endcase
          end
        end
    endcase
    case (txState_next)
      SER_START: txLine_next = 1'b0;
      SER_DATA: txLine_next = txShift_next[0];
      SER_PARITY: txLine_next = ^txHold_next ^ ctrl_reg[CTRL_PARITY_ODD];
      default: txLine_next = 1'b1; // RL13
    endcase
    if (ctrl_reg[CTRL_SEND_BREAK])
      txLine_next = 1'b0; // RL7
    txOe_next = ctrl_reg[CTRL_ENABLE] && !chipReq_reg; // RL12
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      txState_reg <= SER_IDLE;
      txTick_reg <= 4'h0;
      txBit_reg <= 3'h0;
      txStop2_reg <= 1'b0;
      txShift_reg <= 8'h00;
      txHold_reg <= 8'h00;
      txLine_reg <= 1'b1;
      txOe_reg <= 1'b0; // RL10
    end
    else
    begin
      txState_reg <= txState_next;
      txTick_reg <= txTick_next;
      txBit_reg <= txBit_next;
      txStop2_reg <= txStop2_next;
      txShift_reg <= txShift_next;
      txHold_reg <= txHold_next;
      txLine_reg <= txLine_next;
      txOe_reg <= txOe_next;
    end
  end

  // Receiver, sampling at mid-bit
  always_comb
  begin
    rxState_next = rxState_reg;
    rxTick_next = rxTick_reg;
    rxBit_next = rxBit_reg;
    rxShift_next = rxShift_reg;
    rxData_next = rxData_reg;
    rxPar_next = rxPar_reg;
    rxFull_next = rxFull_reg && !rxTake;
    rxDone = 1'b0;
    parErr = 1'b0;
    frameErr = 1'b0;
    overrun = 1'b0;
    if (baudBus.tick && ctrl_reg[CTRL_ENABLE])
    begin
      rxTick_next = rxTick_reg + 4'h1;
      case (rxState_reg)
        SER_IDLE:
          if (!rxLine)
          begin
            rxState_next = SER_START;
            rxTick_next = 4'h0;
          end
        SER_START:
          if (rxTick_reg == 4'(OVERSAMPLE / 2 - 1))
          begin
            rxState_next = rxLine ? SER_IDLE : SER_DATA; // RL13
            rxTick_next = 4'h0;
            rxBit_next = 3'h0;
            rxPar_next = ctrl_reg[CTRL_PARITY_ODD];
          end
        SER_DATA:
          if (rxTick_reg == 4'(OVERSAMPLE - 1))
          begin
            rxShift_next = {rxLine, rxShift_reg[7:1]}; // RL13
            rxPar_next = rxPar_reg ^ rxLine;
            rxBit_next = rxBit_reg + 3'h1;
            if (rxBit_reg == 3'h7)
              rxState_next = ctrl_reg[CTRL_PARITY_EN] ? SER_PARITY : SER_STOP;
          end
        SER_PARITY:
          if (rxTick_reg == 4'(OVERSAMPLE - 1))
          begin
            parErr = rxPar_reg ^ rxLine; // RL2
            rxState_next = SER_STOP;
          end
        default:
          if (rxTick_reg == 4'(OVERSAMPLE - 1))
          begin
            rxState_next = SER_IDLE;
            frameErr = !rxLine;
            rxDone = 1'b1;
            overrun = rxFull_reg && !rxTake;
            rxData_next = rxShift_reg;
            rxFull_next = 1'b1;
          end
      endcase
    end
    rtsN_next = ctrl_reg[CTRL_FLOW_EN] && rxFull_next; // RL1
    rtsOe_next = ctrl_reg[CTRL_ENABLE] && !chipReq_reg; // RL12
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rxState_reg <= SER_IDLE;
      rxTick_reg <= 4'h0;
      rxBit_reg <= 3'h0;
      rxShift_reg <= 8'h00;
      rxData_reg <= 8'h00;
      rxPar_reg <= 1'b0;
      rxFull_reg <= 1'b0;
      rtsN_reg <= 1'b1;
      rtsOe_reg <= 1'b0; // RL10
    end
    else
    begin
      rxState_reg <= rxState_next;
      rxTick_reg <= rxTick_next;
      rxBit_reg <= rxBit_next;
      rxShift_reg <= rxShift_next;
      rxData_reg <= rxData_next;
      rxPar_reg <= rxPar_next;
      rxFull_reg <= rxFull_next;
      rtsN_reg <= rtsN_next;
      rtsOe_reg <= rtsOe_next;
    end
  end

  // Break duration measurement and chip reset request
  always_comb
  begin
    brkPre_next = 32'h00000000;
    brkUnits_next = 16'h0000;
    brkFired_next = 1'b0;
    brkFire = 1'b0;
    if (!rxLine && ctrl_reg[CTRL_ENABLE])
    begin
      brkFired_next = brkFired_reg;
      brkUnits_next = brkUnits_reg;
      brkPre_next = brkPre_reg + 32'h00000001;
      if (brkPre_reg == 32'(BREAK_UNIT - 1))
      begin
        brkPre_next = 32'h00000000;
        if (brkUnits_reg != 16'hFFFF)
          brkUnits_next = brkUnits_reg + 16'h0001;
      end
      if (brkUnits_reg > timeout_reg && !brkFired_reg)
      begin
        brkFire = 1'b1; // RL6
        brkFired_next = 1'b1;
      end
    end
    chipReq_next = resetPin || powerOnDetect || watchdogExpire || brkFire; // RL9
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      brkPre_reg <= 32'h00000000;
      brkUnits_reg <= 16'h0000;
      brkFired_reg <= 1'b0;
      chipReq_reg <= 1'b0;
    end
    else
    begin
      brkPre_reg <= brkPre_next;
      brkUnits_reg <= brkUnits_next;
      brkFired_reg <= brkFired_next;
      chipReq_reg <= chipReq_next;
    end
  end

  assign regRdata = rdata_reg;
  assign irq = irq_reg;
  assign txLine = txLine_reg;
  assign txOe = txOe_reg;
  assign rtsN = rtsN_reg;
  assign rtsOe = rtsOe_reg;
  assign chipResetReq = chipReq_reg;

  sequence tickGap;
    (!baudBus.tick) [*8] ##[1:TICK_MAX_WAIT] baudBus.tick;
  endsequence

  a_tx_cts_hold: assert property (@(posedge clock) disable iff (rst) // RL1
    (txState_reg == SER_IDLE && ctrl_reg[CTRL_FLOW_EN] && ctsN) |=> txState_reg != SER_START)
    else $error("transmit started while clear-to-send high");
  a_rts_full: assert property (@(posedge clock) disable iff (rst) // RL1
    (ctrl_reg[CTRL_FLOW_EN] && rxFull_reg && !rxTake) |=> rtsN_reg)
    else $error("request-to-send low while receive data unread");
  a_parity_bit: assert property (@(posedge clock) disable iff (rst) // RL2
    (txState_reg == SER_PARITY && !ctrl_reg[CTRL_SEND_BREAK])
      |-> txLine_reg == (^txHold_reg ^ ctrl_reg[CTRL_PARITY_ODD]))
    else $error("wrong parity bit on transmit line");
  a_baud_gap: assert property (@(posedge clock) disable iff (rst) // RL4
    (baudBus.tick && baud_reg == BAUD_RESET && $stable(baud_reg)) |=> tickGap)
    else $error("oversample tick spacing wrong for default rate");
  a_break_fire: assert property (@(posedge clock) disable iff (rst) // RL6
    brkFire |=> chipReq_reg && status_reg[EV_BREAK])
    else $error("break did not request chip reset");
  a_break_send: assert property (@(posedge clock) disable iff (rst) // RL7
    ctrl_reg[CTRL_SEND_BREAK] |=> !txLine_reg)
    else $error("transmit line not held low during break");
  a_reset_sources: assert property (@(posedge clock) disable iff (rst) // RL9
    (resetPin || powerOnDetect || watchdogExpire) |=> chipReq_reg)
    else $error("reset source not passed to chip reset");
  a_reset_float: assert property (@(posedge clock) disable iff (rst) // RL12
    chipReq_reg |=> !txOe_reg && !rtsOe_reg)
    else $error("serial outputs driven during chip reset");
  a_warm_keep: assert property (@(posedge clock) // RL11
    (rst && !coldReset) |=> baud_reg == $past(baud_reg))
    else $error("rate setting lost on warm reset");
  a_start_low: assert property (@(posedge clock) disable iff (rst) // RL13
    (txState_reg == SER_START) |-> !txLine_reg)
    else $error("start bit not low");
endmodule : uart_break_reset

// ---- testbench/host_uart_model.sv ----
// Host-side serial port model facing the device's receive and transmit lines
module host_uart_model
(
  input wire logic clock,
  input wire logic txLine,
  output logic rxLine,
  output logic ctsN
);
  timeunit 1ns;
  timeprecision 100ps;
  int bitCycles = 85;

  initial
  begin
    rxLine = 1'b1;
    ctsN = 1'b0;
  end

  // One frame: low start bit, data least significant bit first, one high stop
  task automatic send(input logic [7:0] data);
    logic [9:0] frame;
    frame = {1'b1, data, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clock);
      rxLine <= frame[i];
      repeat (bitCycles - 1) @(posedge clock);
    end
  endtask : send

  task automatic holdLow(input int n);
    @(posedge clock);
    rxLine <= 1'b0;
    repeat (n) @(posedge clock);
    rxLine <= 1'b1;
  endtask : holdLow

  // Clear-to-send level seen by the device, low lets it send
  task automatic setCts(input logic v);
    ctsN <= v;
  endtask : setCts

  // Samples each bit near its middle; ok falls if start or stop level is wrong
  task automatic recv(input logic parEn, output logic [7:0] data, output logic par,
    output logic ok);
    int t;
    t = 0;
    ok = 1'b0;
    data = 8'h00;
    par = 1'b0;
    while (txLine !== 1'b0 && t < 400)
    begin
      @(posedge clock);
      t++;
    end
    if (t < 400)
    begin
      repeat (bitCycles / 2) @(posedge clock);
      ok = (txLine === 1'b0);
      for (int i = 0; i < 8; i++)
      begin
        repeat (bitCycles) @(posedge clock);
        data[i] = txLine;
      end
      if (parEn)
      begin
        repeat (bitCycles) @(posedge clock);
        par = txLine;
      end
      repeat (bitCycles) @(posedge clock);
      ok = ok && (txLine === 1'b1);
    end
  endtask : recv
endmodule : host_uart_model

// ---- testbench/uart_break_reset_tb.sv ----
// Self-checking bench for the serial port with break reset
module uart_break_reset_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import uart_pkg::*;
  localparam int BU = 10;
  logic clock;
  logic rst;
  logic [ADDR_W-1:0] regAddr;
  logic [31:0] regWdata;
  logic regWrite;
  logic regRead;
  logic [31:0] regRdata;
  logic rxLine, ctsN, txLine, txOe, rtsN, rtsOe, irq;
  logic resetPin, powerOnDetect, watchdogExpire, coldReset, chipResetReq;
  logic [31:0] rv;
  logic [7:0] d;
  int n_mismatch = 0;
  int checks_done = 0;
  int nReq = 0;
  int t;

  uart_break_reset #(.BREAK_UNIT(BU)) u_dut (.clock(clock), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .rxLine(rxLine), .ctsN(ctsN), .txLine(txLine), .txOe(txOe), .rtsN(rtsN), .rtsOe(rtsOe),
    .irq(irq), .resetPin(resetPin), .powerOnDetect(powerOnDetect),
    .watchdogExpire(watchdogExpire), .coldReset(coldReset), .chipResetReq(chipResetReq));
  host_uart_model host (.clock(clock), .txLine(txLine), .rxLine(rxLine), .ctsN(ctsN));

  always @(posedge clock)
    if (chipResetReq === 1'b1 && rst === 1'b0)
      nReq++;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    regAddr <= a;
    regWdata <= v;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask : wr

  task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1;
    rv = regRdata;
    check(what, rv, exp);
  endtask : rdChk

  task automatic doReset(input logic cold);
    @(posedge clock);
    rst <= 1'b1;
    coldReset <= cold;
    repeat (4) @(posedge clock);
    #1;
    check("txOe in reset", {31'h0, txOe}, 32'h0);
    check("rtsOe in reset", {31'h0, rtsOe}, 32'h0);
    @(posedge clock);
    rst <= 1'b0;
    coldReset <= 1'b0;
    repeat (2) @(posedge clock);
  endtask : doReset

  task automatic txFrame(input logic [7:0] v, input logic parEn, input logic expPar);
    logic [7:0] got;
    logic p;
    logic ok;
    fork
      host.recv(parEn, got, p, ok);
      wr(REG_TXDATA, {24'h0, v});
    join
    check("tx data", {24'h0, got}, {24'h0, v});
    check("tx framing", {31'h0, ok}, 32'h1);
    if (parEn)
      check("tx parity", {31'h0, p}, {31'h0, expPar});
    repeat (2 * host.bitCycles) @(posedge clock);
  endtask : txFrame

  task automatic conclude;
    $display("Comparisons %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude

  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  initial
  begin
    repeat (100000) @(posedge clock);
    n_mismatch++;
    conclude();
  end

  initial
  begin
    {rst, regAddr, regWdata, regWrite, regRead} = '0;
    {resetPin, powerOnDetect, watchdogExpire, coldReset} = '0;
    doReset(1'b1);
    rdChk("ctrl", REG_CTRL, 32'h01);
    rdChk("baud", REG_BAUD, 32'h01D8);
    rdChk("timeout", REG_TIMEOUT, 32'h01A4);
    rdChk("unmapped", 8'h20, 32'h0);
    $display("Test defaults done");
    wr(REG_BAUD, 32'h0EBF);
    host.bitCycles = 271;
    txFrame(8'hA5, 1'b0, 1'b0);
    wr(REG_BAUD, 32'h2EE0);
    host.bitCycles = 85;
    for (int m = 0; m < 3; m++)
    begin
      wr(REG_CTRL, (m == 0) ? 32'h01 : (m == 1) ? 32'h07 : 32'h0B);
      d = 8'h31 << m;
      txFrame(d, m != 0, (m == 1) ? ~^d : ^d);
    end
    $display("Test transmit formats done");
    wr(REG_CTRL, 32'h01);
    wr(REG_STATUS, 32'h3F);
    host.send(8'hC3);
    repeat (170) @(posedge clock);
    rdChk("state full", REG_STATE, 32'h14);
    rdChk("rx data", REG_RXDATA, 32'hC3);
    rdChk("status", REG_STATUS, 32'h01);
    wr(REG_MASK, 32'h01);
    repeat (2) @(posedge clock);
    check("irq set", {31'h0, irq}, 32'h1);
    wr(REG_STATUS, 32'h01);
    repeat (2) @(posedge clock);
    check("irq clear", {31'h0, irq}, 32'h0);
    wr(REG_MASK, 32'h0);
    // Host sends no parity bit, so its stop bit stands where parity is expected
    wr(REG_CTRL, 32'h03);
    host.send(8'hC3);
    repeat (170) @(posedge clock);
    host.send(8'hC3);
    repeat (170) @(posedge clock);
    rdChk("rx even overrun", REG_STATUS, 32'h15);
    rdChk("rx drain", REG_RXDATA, 32'hC3);
    wr(REG_CTRL, 32'h07);
    wr(REG_STATUS, 32'h3F);
    host.send(8'hC3);
    repeat (170) @(posedge clock);
    rdChk("rx odd", REG_STATUS, 32'h01);
    // An all-low frame whose stop bit is low as well
    wr(REG_CTRL, 32'h01);
    host.holdLow(830);
    repeat (170) @(posedge clock);
    rdChk("rx frame", REG_STATUS, 32'h19);
    rdChk("rx zero", REG_RXDATA, 32'h00);
    $display("Test receive done");
    wr(REG_CTRL, 32'h11);
    @(posedge clock);
    host.setCts(1'b1);
    wr(REG_TXDATA, 32'h77);
    repeat (20) @(posedge clock);
    check("tx held", {31'h0, txLine}, 32'h1);
    rdChk("state idle", REG_STATE, 32'h10);
    host.send(8'h0F);
    repeat (170) @(posedge clock);
    check("rts full", {31'h0, rtsN}, 32'h1);
    rdChk("rx flow", REG_RXDATA, 32'h0F);
    repeat (3) @(posedge clock);
    check("rts free", {31'h0, rtsN}, 32'h0);
    @(posedge clock);
    host.setCts(1'b0);
    txFrame(8'h77, 1'b0, 1'b0);
    $display("Test flow control done");
    wr(REG_CTRL, 32'h21);
    repeat (2) @(posedge clock);
    check("break tx", {30'h0, txLine, txOe}, 32'h1);
    wr(REG_CTRL, 32'h01);
    wr(REG_STATUS, 32'h3F);
    wr(REG_TIMEOUT, 32'h03);
    host.holdLow(3 * BU - 2);
    repeat (5) @(posedge clock);
    check("short low", nReq, 0);
    fork
      host.holdLow(5 * BU);
    join_none
    t = 0;
    while (chipResetReq !== 1'b1 && t < 200)
    begin
      @(posedge clock);
      #1;
      t++;
    end
    check("break fired", {31'h0, t < 200}, 32'h1);
    @(posedge clock);
    #1;
    check("oe off", {30'h0, txOe, rtsOe}, 32'h0);
    rdChk("break state", REG_STATE, 32'h0A);
    wait fork;
    rdChk("break status", REG_STATUS, 32'h20);
    check("one fire", nReq, 1);
    $display("Test break reset done");
    doReset(1'b0);
    rdChk("warm baud", REG_BAUD, 32'h2EE0);
    for (int s = 0; s < 3; s++)
    begin
      @(posedge clock);
      {resetPin, powerOnDetect, watchdogExpire} <= 3'b100 >> s;
      @(posedge clock);
      {resetPin, powerOnDetect, watchdogExpire} <= 3'b000;
      #1;
      check("reset source", {31'h0, chipResetReq}, 32'h1);
      repeat (3) @(posedge clock);
    end
    doReset(1'b1);
    rdChk("cold baud", REG_BAUD, 32'h01D8);
    $display("Test reset kinds done");
    conclude();
  end
endmodule : uart_break_reset_tb
